//--- common/wake_cfg_pkg.sv
// Constants for the wake-up frame configuration bank
package wake_cfg_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam logic [6:0] OFF_WAKE_CTRL              = 7'h20;
  localparam logic [6:0] OFF_WAKE_ID_MID_HIGH       = 7'h24;
  localparam logic [6:0] OFF_WAKE_ID_MID_LOW        = 7'h25;
  localparam logic [6:0] OFF_WAKE_ID_LOW_FORMAT     = 7'h26;
  localparam logic [6:0] OFF_WAKE_ID_COMPARE_TOP    = 7'h27;
  localparam logic [6:0] OFF_WAKE_ID_COMPARE_MID_HI = 7'h28;
  localparam logic [6:0] OFF_WAKE_ID_COMPARE_MID_LO = 7'h29;
  localparam logic [6:0] OFF_WAKE_ID_COMPARE_LOW    = 7'h2a;
  localparam logic [6:0] OFF_WAKE_LENGTH_CODE       = 7'h2b;
  localparam logic [6:0] OFF_WAKE_PAYLOAD_BYTE7     = 7'h2c;
  localparam logic [6:0] OFF_WAKE_PAYLOAD_BYTE6     = 7'h2d;
  localparam logic [7:0] RESET_BYTE                 = 8'h00;
  localparam int LOW_ID_MSB     = 6;
  localparam int LOW_ID_LSB     = 2;
  localparam int RTR_BIT        = 1;
  localparam int IDE_BIT        = 0;
  localparam int CFG_VALID_BIT  = 0;
  localparam logic [3:0] MAX_PAYLOAD = 4'h8;
  localparam logic [28:0] STD_ID_FIELD = 29'h1ffc0000;
endpackage : wake_cfg_pkg

//--- core/wake_frame_filter_config.sv
// Wake-up frame reference register bank with frame comparator
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
// Function
// RULE1: Register holds identifier bits 20 to 13
// RULE2: Register holds identifier bits 12 to 5
// RULE3: Identifier bits 4..0 at 6..2, bit7 zero
// RULE4: Bit 1 holds expected remote request flag
// RULE5: Software never sets remote request flag
// RULE6: Bit 0 selects standard or extended identifier
// RULE7: Mask one compares bit, zero ignores
// RULE8: Four mask registers, unused positions read zero
// RULE9: Length code in bits 3..0, upper zero
// RULE10: Codes above seven mean eight bytes
// RULE11: Two byte registers hold payload bytes 7, 6
// RULE12: Power-on and soft reset clear everything
// RULE13: Restart keeps contents, reserved bits read zero
// RULE14: Valid flag clears on wake, reset, change; a control write in the same cycle as a wake sets it from bit 0 instead
// RULE15: Standard identifier sits in bits 28..18
// RULE16: Match needs compared bits, format, remote, length
module wake_frame_filter_config
  import wake_cfg_pkg::*;
(
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  input  wire logic                          soft_rst,
  input  wire logic [wake_cfg_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [wake_cfg_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [wake_cfg_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic [7:0]                    ref_id_top_bits,
  input  wire logic                          wake_event,
  input  wire logic                          frame_valid,
  input  wire logic [28:0]                   frame_id,
  input  wire logic                          frame_ide,
  input  wire logic                          frame_rtr,
  input  wire logic [3:0]                    frame_dlc,
  output logic                               wake_config_valid,
  output logic                               wake_up_frame,
  output logic      [3:0]                    payload_len,
  output logic      [7:0]                    payload_byte_seven,
  output logic      [7:0]                    payload_byte_six
);
  import wake_cfg_pkg::*;

  logic [7:0]  frame_id_mid_high_bits_reg;
  logic [7:0]  frame_id_mid_low_bits_reg;
  logic [4:0]  frame_id_low_bits_reg;
  logic        rtr_reg;
  logic        ide_reg;
  logic [7:0]  compare_sel_top_bits_reg;
  logic [7:0]  compare_sel_mid_high_bits_reg;
  logic [7:0]  compare_sel_mid_low_bits_reg;
  logic [4:0]  compare_sel_low_bits_reg;
  logic [3:0]  dlc_reg;
  logic [7:0]  byte7_reg;
  logic [7:0]  byte6_reg;
  logic        cfg_valid_reg;
  logic        match_reg;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic        cfg_write;
  logic [28:0] ref_id;
  logic [28:0] sel_mask;
  logic        frame_ok;

  // Any write to the frame description is a configuration change
  assign cfg_write = reg_wr && (reg_addr >= OFF_WAKE_ID_MID_HIGH) &&
                     (reg_addr <= OFF_WAKE_PAYLOAD_BYTE6);

  // Restart is not modelled: nothing here is touched by it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      frame_id_mid_high_bits_reg <= RESET_BYTE; // see RULE12
      frame_id_mid_low_bits_reg  <= RESET_BYTE;
      frame_id_low_bits_reg      <= RESET_BYTE[4:0];
      rtr_reg                    <= 1'b0;
      ide_reg                    <= 1'b0;
    end else if (soft_rst) begin
      frame_id_mid_high_bits_reg <= RESET_BYTE; // see RULE12
      frame_id_mid_low_bits_reg  <= RESET_BYTE;
      frame_id_low_bits_reg      <= RESET_BYTE[4:0];
      rtr_reg                    <= 1'b0;
      ide_reg                    <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == OFF_WAKE_ID_MID_HIGH) begin
        frame_id_mid_high_bits_reg <= reg_wdata; // see RULE1
      end
      if (reg_addr == OFF_WAKE_ID_MID_LOW) begin
        frame_id_mid_low_bits_reg <= reg_wdata; // see RULE2
      end
      if (reg_addr == OFF_WAKE_ID_LOW_FORMAT) begin
        frame_id_low_bits_reg <= reg_wdata[LOW_ID_MSB:LOW_ID_LSB]; // see RULE3
        // Stored as written; a set flag simply never matches a data frame
        rtr_reg <= reg_wdata[RTR_BIT]; // see RULE4
        ide_reg <= reg_wdata[IDE_BIT]; // see RULE6
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      compare_sel_top_bits_reg      <= RESET_BYTE; // see RULE12
      compare_sel_mid_high_bits_reg <= RESET_BYTE;
      compare_sel_mid_low_bits_reg  <= RESET_BYTE;
      compare_sel_low_bits_reg      <= RESET_BYTE[4:0];
    end else if (soft_rst) begin
      compare_sel_top_bits_reg      <= RESET_BYTE; // see RULE12
      compare_sel_mid_high_bits_reg <= RESET_BYTE;
      compare_sel_mid_low_bits_reg  <= RESET_BYTE;
      compare_sel_low_bits_reg      <= RESET_BYTE[4:0];
    end else if (reg_wr) begin
      if (reg_addr == OFF_WAKE_ID_COMPARE_TOP) begin
        compare_sel_top_bits_reg <= reg_wdata; // see RULE8
      end
      if (reg_addr == OFF_WAKE_ID_COMPARE_MID_HI) begin
        compare_sel_mid_high_bits_reg <= reg_wdata; // see RULE8
      end
      if (reg_addr == OFF_WAKE_ID_COMPARE_MID_LO) begin
        compare_sel_mid_low_bits_reg <= reg_wdata; // see RULE8
      end
      if (reg_addr == OFF_WAKE_ID_COMPARE_LOW) begin
        compare_sel_low_bits_reg <= reg_wdata[LOW_ID_MSB:LOW_ID_LSB]; // see RULE8
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dlc_reg   <= RESET_BYTE[3:0]; // see RULE12
      byte7_reg <= RESET_BYTE;
      byte6_reg <= RESET_BYTE;
    end else if (soft_rst) begin
      dlc_reg   <= RESET_BYTE[3:0]; // see RULE12
      byte7_reg <= RESET_BYTE;
      byte6_reg <= RESET_BYTE;
    end else if (reg_wr) begin
      if (reg_addr == OFF_WAKE_LENGTH_CODE) begin
        dlc_reg <= reg_wdata[3:0]; // see RULE9
      end
      if (reg_addr == OFF_WAKE_PAYLOAD_BYTE7) begin
        byte7_reg <= reg_wdata; // see RULE11
      end
      if (reg_addr == OFF_WAKE_PAYLOAD_BYTE6) begin
        byte6_reg <= reg_wdata; // see RULE11
      end
    end
  end

  // Software set wins over a wake or change clear in the same cycle; only reset or soft reset overrides it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_valid_reg <= 1'b0; // see RULE14
    end else if (soft_rst) begin
      cfg_valid_reg <= 1'b0;
    end else if (reg_wr && reg_addr == OFF_WAKE_CTRL) begin
      cfg_valid_reg <= reg_wdata[CFG_VALID_BIT];
    end else if (wake_event || cfg_write) begin
      cfg_valid_reg <= 1'b0; // see RULE14
    end
  end

  // Standard frames use only the top eleven identifier positions
  assign ref_id   = {ref_id_top_bits, frame_id_mid_high_bits_reg,
                     frame_id_mid_low_bits_reg, frame_id_low_bits_reg};
  assign sel_mask = {compare_sel_top_bits_reg, compare_sel_mid_high_bits_reg,
                     compare_sel_mid_low_bits_reg, compare_sel_low_bits_reg} &
                    (ide_reg ? {29{1'b1}} : STD_ID_FIELD); // see RULE15

  assign frame_ok = (((frame_id ^ ref_id) & sel_mask) == 29'h0) && // see RULE7
                    (frame_ide == ide_reg) &&
                    (frame_rtr == rtr_reg) &&
                    (frame_dlc == dlc_reg); // see RULE16

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      match_reg <= 1'b0;
    end else begin
      match_reg <= frame_valid && frame_ok && cfg_valid_reg && !soft_rst; // see RULE16
    end
  end

  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        OFF_WAKE_CTRL:              rdata_next = {7'h00, cfg_valid_reg};
        OFF_WAKE_ID_MID_HIGH:       rdata_next = frame_id_mid_high_bits_reg; // see RULE1
        OFF_WAKE_ID_MID_LOW:        rdata_next = frame_id_mid_low_bits_reg; // see RULE2
        OFF_WAKE_ID_LOW_FORMAT:     rdata_next = {1'b0, frame_id_low_bits_reg,
                                                  rtr_reg, ide_reg}; // see RULE3
        OFF_WAKE_ID_COMPARE_TOP:    rdata_next = compare_sel_top_bits_reg;
        OFF_WAKE_ID_COMPARE_MID_HI: rdata_next = compare_sel_mid_high_bits_reg;
        OFF_WAKE_ID_COMPARE_MID_LO: rdata_next = compare_sel_mid_low_bits_reg;
        OFF_WAKE_ID_COMPARE_LOW:    rdata_next = {1'b0, compare_sel_low_bits_reg,
                                                  2'b00}; // see RULE13
        OFF_WAKE_LENGTH_CODE:       rdata_next = {4'h0, dlc_reg}; // see RULE9
        OFF_WAKE_PAYLOAD_BYTE7:     rdata_next = byte7_reg;
        OFF_WAKE_PAYLOAD_BYTE6:     rdata_next = byte6_reg;
        default:                    rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata          = rdata_reg;
  assign wake_config_valid  = cfg_valid_reg;
  assign wake_up_frame      = match_reg;
  assign payload_len        = (dlc_reg > 4'h7) ? MAX_PAYLOAD : dlc_reg; // see RULE10
  assign payload_byte_seven = byte7_reg;
  assign payload_byte_six   = byte6_reg;

endmodule : wake_frame_filter_config

//--- verification/wake_cfg_monitor.sv
// Checker on the wake frame configuration bank ports
`timescale 1ns/10ps
module wake_cfg_monitor
  import wake_cfg_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       soft_rst,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       wake_event,
  input wire logic       frame_valid,
  input wire logic       wake_config_valid,
  input wire logic       wake_up_frame,
  input wire logic [3:0] payload_len,
  input wire logic [7:0] payload_byte_seven
);
  logic [3:0] len_exp_reg;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Expected length one cycle after a length write
  always_ff @(posedge ref_clk) begin
    len_exp_reg <= (reg_wdata[3:0] > 4'h7) ? MAX_PAYLOAD : reg_wdata[3:0];
  end
  sequence s_rd(a); reg_rd && reg_addr == a; endsequence
  sequence s_wr(a); reg_wr && reg_addr == a && !soft_rst; endsequence
  AST_LOW_RSV: assert property (s_rd(OFF_WAKE_ID_LOW_FORMAT) |=> !reg_rdata[7])
    else $error("low id bit 7 not zero");
  AST_MASK_RSV: assert property (
    s_rd(OFF_WAKE_ID_COMPARE_LOW) |=> (reg_rdata & 8'h83) == 8'h00)
    else $error("low mask reserved bits set");
  AST_DLC_RSV: assert property (
    s_rd(OFF_WAKE_LENGTH_CODE) |=> reg_rdata[7:4] == 4'h0)
    else $error("length upper bits set");
  AST_LEN: assert property (
    s_wr(OFF_WAKE_LENGTH_CODE) |=> payload_len == len_exp_reg)
    else $error("payload length wrong");
  AST_BYTE7: assert property (
    s_wr(OFF_WAKE_PAYLOAD_BYTE7) |=> payload_byte_seven == $past(reg_wdata))
    else $error("byte seven not stored");
  AST_SOFT: assert property (
    soft_rst |=> !wake_config_valid && payload_len == 4'h0 && payload_byte_seven == 8'h00)
    else $error("soft reset left state");
  AST_CHG: assert property (
    reg_wr && reg_addr >= OFF_WAKE_ID_MID_HIGH && reg_addr <= OFF_WAKE_PAYLOAD_BYTE6
    |=> !wake_config_valid)
    else $error("valid kept after change");
  AST_WAKE: assert property (
    wake_event && !(reg_wr && reg_addr == OFF_WAKE_CTRL) |=> !wake_config_valid)
    else $error("valid kept after wake");
  AST_MATCH: assert property (
    wake_up_frame |-> $past(frame_valid) && $past(wake_config_valid) && !$past(soft_rst))
    else $error("match without valid frame");
endmodule : wake_cfg_monitor
bind wake_frame_filter_config wake_cfg_monitor mon (.*);

//--- verification/can_node_model.sv
// Bus node model offering received frames to the matcher
`timescale 1ns/10ps
module can_node_model (
  input  wire logic        ref_clk,
  output logic             frame_valid,
  output logic [28:0]      frame_id,
  output logic             frame_ide,
  output logic             frame_rtr,
  output logic [3:0]       frame_dlc
);
  initial {frame_valid, frame_id, frame_ide, frame_rtr, frame_dlc} = '0;
  // Idle fields show the inverse so stale values never pass as a frame
  task automatic send(input logic [28:0] id, input logic ide, rtr,
                      input logic [3:0] dl, input int gap);
    repeat (gap) @(posedge ref_clk);
    {frame_valid, frame_id, frame_ide, frame_rtr, frame_dlc} <= {1'b1, id, ide, rtr, dl};
    @(posedge ref_clk);
    {frame_valid, frame_id, frame_ide, frame_rtr, frame_dlc} <= {1'b0, ~id, ~ide, ~rtr, ~dl};
  endtask : send
endmodule : can_node_model

//--- verification/tb.sv
// Self-checking bench for the wake frame configuration bank
`timescale 1ns/10ps
module tb;
  import wake_cfg_pkg::*;
  logic        ref_clk, rst, soft_rst, reg_wr, reg_rd, wake_event, frame_valid, frame_ide;
  logic        frame_rtr, wake_config_valid, wake_up_frame, rd_d = 0, fv_d = 0;
  logic [6:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, ref_id_top_bits, payload_byte_seven, payload_byte_six, d;
  logic [28:0] frame_id, r;
  logic [3:0]  frame_dlc, payload_len;
  logic [7:0]  q[$];
  logic [7:0]  exp_reg[0:15];
  int          error_cnt = 0, samples_checked = 0, seed = 65, i;
  can_node_model node (.*);
  wake_frame_filter_config dut (.*);
  initial begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input string n, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, rd, input logic [6:0] a, input logic [7:0] v);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, rd, a, v};
    @(posedge ref_clk);
  endtask : bus
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    bus(1, 0, a, v);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    q.push_back(e);
    bus(0, 1, a, 8'h00);
  endtask : rd
  task automatic zeros;
    for (i = 32; i < 46; i++) rd(i[6:0], 8'h00);
  endtask : zeros
  task automatic frm(input logic [28:0] id, input logic ide, rtr,
                     input logic [3:0] dl, input logic e);
    bus(0, 0, 7'h00, 8'h00);
    q.push_back({7'h00, e});
    node.send(id, ide, rtr, dl, 1 + ($random(seed) & 3));
  endtask : frm
  task automatic results;
    // Expected results never consumed mean a response went missing
    if (q.size() != 0) begin
      error_cnt++;
      $display("BAD pending exp %0d got %0d", 0, q.size());
    end
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  // Outputs settle well before the falling edge
  always @(negedge ref_clk) begin
    if (rd_d) chk("rdata", q.pop_front(), reg_rdata);
    if (fv_d) chk("match", q.pop_front(), {7'h00, wake_up_frame});
    rd_d = reg_rd;
    fv_d = frame_valid;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    results();
  end
  initial begin
    {rst, soft_rst, wake_event, ref_id_top_bits} = {1'b1, 1'b0, 1'b0, 8'h00};
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    zeros();
    for (i = 36; i < 46; i++) begin
      d = $random(seed);
      if (i == 38) d[1] = 1'b0;
      wr(i[6:0], d);
      exp_reg[i[3:0]] = d & (i == 38 ? 8'h7f : i == 42 ? 8'h7c : i == 43 ? 8'h0f : 8'hff);
    end
    wr(7'h30, 8'hff);
    rd(7'h30, 8'h00);
    for (i = 36; i < 46; i++) begin
      rd(i[6:0], exp_reg[i[3:0]]);
    end
    chk("byte7", exp_reg[12], payload_byte_seven);
    chk("byte6", exp_reg[13], payload_byte_six);
    for (i = 0; i < 16; i++) begin
      wr(OFF_WAKE_LENGTH_CODE, i[7:0]);
      bus(0, 0, 7'h00, 8'h00);
      chk("len", (i > 7) ? 8'h08 : i[7:0], {4'h0, payload_len});
    end
    r = 29'($random(seed));
    ref_id_top_bits <= r[28:21];
    wr(OFF_WAKE_ID_MID_HIGH, r[20:13]);
    wr(OFF_WAKE_ID_MID_LOW, r[12:5]);
    wr(OFF_WAKE_ID_LOW_FORMAT, {1'b0, r[4:0], 2'b01});
    for (i = 39; i < 42; i++) wr(i[6:0], 8'hff);
    wr(OFF_WAKE_ID_COMPARE_LOW, 8'h7c);
    wr(OFF_WAKE_LENGTH_CODE, 8'h05);
    wr(OFF_WAKE_CTRL, 8'h01);
    rd(OFF_WAKE_CTRL, 8'h01);
    chk("valid", 8'h01, {7'h00, wake_config_valid});
    frm(r, 1, 0, 4'h5, 1);
    frm(r ^ 29'h1, 1, 0, 4'h5, 0);
    frm(r, 0, 0, 4'h5, 0);
    frm(r, 1, 1, 4'h5, 0);
    frm(r, 1, 0, 4'h4, 0);
    wr(OFF_WAKE_LENGTH_CODE, 8'h05);
    frm(r, 1, 0, 4'h5, 0);
    wr(OFF_WAKE_CTRL, 8'h01);
    wake_event <= 1'b1;
    bus(0, 0, 7'h00, 8'h00);
    wake_event <= 1'b0;
    frm(r, 1, 0, 4'h5, 0);
    chk("valid", 8'h00, {7'h00, wake_config_valid});
    wr(OFF_WAKE_ID_LOW_FORMAT, {1'b0, r[4:0], 2'b00});
    wr(OFF_WAKE_ID_COMPARE_TOP, 8'h00);
    wr(OFF_WAKE_CTRL, 8'h01);
    frm(r ^ 29'h1003ffff, 0, 0, 4'h5, 1);
    soft_rst <= 1'b1;
    bus(0, 0, 7'h00, 8'h00);
    soft_rst <= 1'b0;
    zeros();
    bus(0, 0, 7'h00, 8'h00);
    repeat (3) @(posedge ref_clk);
    results();
  end
endmodule : tb
